//--- hw/encoder_readout_pkg.sv
// Shared constants, register map and mode encoding for the encoder serial readout
package encoder_readout_pkg;

    // Position word layout: tracks on top, sine bit, then interpolated bits
    localparam int WORD_W = 16;
    localparam int TRACK_W = 11;
    localparam int INTERP_W = 4;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] FULL_WORD_BITS = 5'h10;

    // Pins passing the two-stage synchroniser
    localparam int PIN_W = 8 + TRACK_W + INTERP_W;

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_POSITION = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_LINK = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Interrupt status and mask fields
    localparam int IRQ_W = 3;
    localparam int ST_LIGHT = 0;
    localparam int ST_START = 1;
    localparam int ST_DONE = 2;

    // Control fields
    localparam int CTRL_W = 3;
    localparam int CTRL_OVERRIDE = 0;
    localparam int CTRL_INVERT = 1;
    localparam int CTRL_CORRECT = 2;

    // Link status fields
    localparam int LINK_LIGHT = 0;
    localparam int LINK_LOAD = 1;
    localparam int LINK_CNT_LSB = 2;

    // Shift register mode
    typedef enum logic [2:0]
    {
        MODE_LOAD = 3'h1,
        MODE_SHIFT = 3'h2,
        MODE_DONE = 3'h4
    } mode_e;

endpackage : encoder_readout_pkg

//--- hw/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : pin_sync

//--- hw/encoder_serial_position_readout.sv
// Serial position readout: load/shift register, pin status, interrupts, AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Operation
// - Load mode holds serial output at MSB
// - Each shift clock pulse advances one bit
// - Word leaves most significant bit first
// - Direction select inverts MSB, still first
// - Correction touches only upper eleven bits
// - Light error high while emitter light low
// - Sine and cosine bits on test outputs
// - Control high loads, low shifts
// - Correction off passes track bits unaltered
module encoder_serial_position_readout (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load_shift_select,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic direction_invert,
    input wire logic gray_correction_enable,
    input wire logic sine_digital,
    input wire logic cosine_digital,
    input wire logic [encoder_readout_pkg::TRACK_W-1:0] track_bits,
    input wire logic [encoder_readout_pkg::INTERP_W-1:0] interp_bits,
    input wire logic light_low,
    output logic serial_out,
    output logic light_error_flag,
    output logic sine_digital_test_out,
    output logic cosine_digital_test_out,
    output logic irq,
    input wire logic awvalid,
    output logic awready,
    input wire logic [encoder_readout_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [encoder_readout_pkg::DATA_W-1:0] wdata,
    input wire logic [encoder_readout_pkg::STRB_W-1:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [encoder_readout_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [encoder_readout_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp
);
    import encoder_readout_pkg::*;

    typedef struct packed {
        mode_e mode;
        logic [WORD_W-1:0] shift_reg;
        logic [WORD_W-1:0] snapshot;
        logic prev_clk;
        logic [BIT_CNT_W-1:0] bit_count;
        logic light_err;
        logic sine_out;
        logic cos_out;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic [CTRL_W-1:0] ctrl;
        logic aw_done;
        logic w_done;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic [PIN_W-1:0] pins_q;
    logic shift_s;
    logic ld_s;
    logic sck_s;
    logic din_s;
    logic inv_s;
    logic corr_s;
    logic sin_s;
    logic cos_s;
    logic lgt_s;
    logic [TRACK_W-1:0] trk_s;
    logic [INTERP_W-1:0] itp_s;
    logic inv_eff;
    logic corr_eff;
    logic sck_rise;
    logic [WORD_W-1:0] word_now;

    // Address decode shared by the read and write paths
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_CTRL) ||
                      (a == OFS_POSITION) || (a == OFS_LINK);
    endfunction : addr_mapped

    // Compose the word; correction and inversion act on track bits only
    function automatic logic [WORD_W-1:0] build_word(
        input logic [TRACK_W-1:0] trk,
        input logic sin,
        input logic cos,
        input logic [INTERP_W-1:0] itp,
        input logic inv,
        input logic corr
    );
        logic [TRACK_W-1:0] t;
        t = trk;
        if (corr)
        begin
            t[0] = cos;
        end
        t[TRACK_W-1] = t[TRACK_W-1] ^ inv;
        build_word = {t, sin, itp};
    endfunction : build_word

    // All pins cross from outside; positions may still skew bit to bit, hence the snapshot
    pin_sync #(.W(PIN_W)) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .d({~load_shift_select, shift_clock, serial_in, direction_invert, gray_correction_enable,
            sine_digital, cosine_digital, light_low, track_bits, interp_bits}),
        .q(pins_q)
    );

    assign {shift_s, sck_s, din_s, inv_s, corr_s, sin_s, cos_s, lgt_s, trk_s, itp_s} = pins_q;
    // Load pin idles high; carried inverted so a cleared synchroniser means load, no false frame start
    assign ld_s = ~shift_s;

    // Software may override the static strap pins
    assign inv_eff = state_reg.ctrl[CTRL_OVERRIDE] ? state_reg.ctrl[CTRL_INVERT] : inv_s;
    assign corr_eff = state_reg.ctrl[CTRL_OVERRIDE] ? state_reg.ctrl[CTRL_CORRECT] : corr_s;
    assign word_now = build_word(trk_s, sin_s, cos_s, itp_s, inv_eff, corr_eff);
    assign sck_rise = sck_s & ~state_reg.prev_clk;

    // Outputs straight from flops except irq, which gates status with mask; bus ready signals are combinational
    assign serial_out = state_reg.shift_reg[WORD_W-1];
    assign light_error_flag = state_reg.light_err;
    assign sine_digital_test_out = state_reg.sine_out;
    assign cosine_digital_test_out = state_reg.cos_out;
    assign irq = |(state_reg.status & state_reg.mask);
    assign awready = ~state_reg.aw_done & ~state_reg.bvalid;
    assign wready = ~state_reg.w_done & ~state_reg.bvalid;
    assign bvalid = state_reg.bvalid;
    assign bresp = state_reg.bresp;
    assign arready = ~state_reg.rvalid;
    assign rvalid = state_reg.rvalid;
    assign rdata = state_reg.rdata;
    assign rresp = state_reg.rresp;

    // Next-state logic for shifter, pin status, interrupts and bus
    always_comb
    begin
        logic [IRQ_W-1:0] ev_set;
        logic [IRQ_W-1:0] ev_clr;
        ev_set = '0;
        ev_clr = '0;
        state_next = state_reg;
        state_next.prev_clk = sck_s;
        state_next.light_err = lgt_s;
        state_next.sine_out = sin_s;
        state_next.cos_out = cos_s;
        if (lgt_s && !state_reg.light_err)
        begin
            ev_set[ST_LIGHT] = 1'b1;
        end

        // Load keeps refreshing the snapshot; shift only moves on clock rises
        unique case (state_reg.mode)
            MODE_LOAD:
            begin
                state_next.shift_reg = word_now;
                state_next.snapshot = word_now;
                state_next.bit_count = '0;
                if (!ld_s)
                begin
                    state_next.mode = MODE_SHIFT;
                    ev_set[ST_START] = 1'b1;
                end
            end
            MODE_SHIFT, MODE_DONE:
            begin
                if (ld_s)
                begin
                    state_next.mode = MODE_LOAD;
                    state_next.shift_reg = word_now;
                    state_next.snapshot = word_now;
                end
                else if (sck_rise)
                begin
                    // MSB is out first; chain input fills from the bottom for cascades
                    state_next.shift_reg = {state_reg.shift_reg[WORD_W-2:0], din_s};
                    if (state_reg.bit_count != FULL_WORD_BITS)
                    begin
                        state_next.bit_count = state_reg.bit_count + 5'h1;
                    end
                    if (state_reg.bit_count == FULL_WORD_BITS - 5'h1)
                    begin
                        state_next.mode = MODE_DONE;
                        ev_set[ST_DONE] = 1'b1;
                    end
                end
            end
            default:
            begin
                state_next.mode = MODE_LOAD;
            end
        endcase

        // Write address and data may arrive in either order
        if (awvalid && awready)
        begin
            state_next.aw_done = 1'b1;
            state_next.waddr = awaddr;
        end
        if (wvalid && wready)
        begin
            state_next.w_done = 1'b1;
            state_next.wdata = wdata;
            state_next.wstrb = wstrb;
        end
        if (state_reg.aw_done && state_reg.w_done)
        begin
            state_next.aw_done = 1'b0;
            state_next.w_done = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = addr_mapped(state_reg.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (state_reg.wstrb[0])
            begin
                unique case (state_reg.waddr)
                    OFS_STATUS: ev_clr = state_reg.wdata[IRQ_W-1:0];
                    OFS_MASK: state_next.mask = state_reg.wdata[IRQ_W-1:0];
                    OFS_CTRL: state_next.ctrl = state_reg.wdata[CTRL_W-1:0];
                    default: ev_clr = '0;
                endcase
            end
        end
        if (state_reg.bvalid && bready)
        begin
            state_next.bvalid = 1'b0;
        end

        // Set wins over a simultaneous write-one clear
        state_next.status = (state_reg.status & ~ev_clr) | ev_set;

        // Reads answer one cycle after the address is taken
        if (arvalid && arready)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp = addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFS_STATUS: state_next.rdata = DATA_W'(state_reg.status);
                OFS_MASK: state_next.rdata = DATA_W'(state_reg.mask);
                OFS_CTRL: state_next.rdata = DATA_W'(state_reg.ctrl);
                OFS_POSITION: state_next.rdata = DATA_W'(state_reg.snapshot);
                OFS_LINK: state_next.rdata = DATA_W'({state_reg.bit_count, ld_s, state_reg.light_err});
                default: state_next.rdata = '0;
            endcase
        end
        else if (state_reg.rvalid && rready)
        begin
            state_next.rvalid = 1'b0;
        end
    end

    // Single state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= '0;
            state_reg.mode <= MODE_LOAD;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence shift_edge;
        state_reg.mode != MODE_LOAD && !ld_s && sck_rise;
    endsequence

    sequence shift_idle;
        state_reg.mode != MODE_LOAD && !ld_s && !sck_rise;
    endsequence

    sequence write_both;
        state_reg.aw_done && state_reg.w_done;
    endsequence

    load_msb_a: assert property (state_reg.mode == MODE_LOAD |=> serial_out == $past(word_now[WORD_W-1]))
        else $error("serial output not at MSB in load mode");
    shift_step_a: assert property (shift_edge |=> state_reg.shift_reg == $past({state_reg.shift_reg[WORD_W-2:0], din_s}))
        else $error("shift register did not advance on clock rise");
    msb_first_a: assert property ((state_reg.mode == MODE_LOAD && !ld_s) |=> state_reg.mode == MODE_SHIFT && serial_out == $past(word_now[WORD_W-1]))
        else $error("first bit of frame is not the MSB");
    invert_a: assert property (state_reg.mode == MODE_LOAD |=> state_reg.shift_reg[WORD_W-1] == ($past(trk_s[TRACK_W-1]) ^ $past(inv_eff)))
        else $error("MSB inversion wrong");
    low_bits_a: assert property (state_reg.mode == MODE_LOAD |=> state_reg.shift_reg[INTERP_W:0] == $past({sin_s, itp_s}))
        else $error("correction altered interpolated bits");
    passthru_a: assert property ((state_reg.mode == MODE_LOAD && !corr_eff) |=> state_reg.shift_reg[WORD_W-2:INTERP_W+1] == $past(trk_s[TRACK_W-2:0]))
        else $error("track bits altered with correction off");
    light_err_a: assert property (lgt_s [*2] |-> light_error_flag)
        else $error("light error not raised");
    test_out_a: assert property (##1 (sine_digital_test_out == $past(sin_s) && cosine_digital_test_out == $past(cos_s)))
        else $error("test outputs do not follow sine and cosine");
    hold_a: assert property (shift_idle |=> $stable(state_reg.shift_reg) && $stable(state_reg.snapshot))
        else $error("word changed during shift without clock");
    mode_sel_a: assert property ((state_reg.mode != MODE_LOAD && ld_s) |=> state_reg.mode == MODE_LOAD)
        else $error("load level did not select load mode");
    word_done_a: assert property (shift_edge ##0 (state_reg.bit_count == FULL_WORD_BITS - 5'h1) |=> state_reg.mode == MODE_DONE && state_reg.status[ST_DONE])
        else $error("full word not flagged");
    write_resp_a: assert property (write_both |=> bvalid [*1] ##0 !awready)
        else $error("write response missing");

endmodule : encoder_serial_position_readout

//--- test/shift_controller_model.sv
// Behavioural external controller that reads serial position frames
`timescale 1ns/1ps
module shift_controller_model (
    output logic load_shift_select,
    output logic shift_clock,
    input wire logic serial_out
);
    logic [15:0] word_got;

    // Idle pins: load high, clock standing still low
    initial
    begin
        load_shift_select = 1'b1;
        shift_clock = 1'b0;
        word_got = 16'h0000;
    end

    // Return to load off the clock edge so the device presents its MSB
    task automatic park();
        #13;
        load_shift_select = 1'b1;
    endtask : park

    // Frame at 400 ns period; odd start offset keeps it unrelated to clk
    task automatic read_frame(input int pulses);
        #13;
        load_shift_select = 1'b1;
        #600;
        load_shift_select = 1'b0;
        word_got = 16'h0000;
        for (int i = 0; i < pulses; i++)
        begin
            #200;
            word_got = {word_got[14:0], serial_out};
            shift_clock = 1'b1;
            #200;
            shift_clock = 1'b0;
        end
        #200;
    endtask : read_frame
endmodule : shift_controller_model

//--- test/testbench.sv
// Self-checking bench for the encoder serial position readout
`timescale 1ns/1ps
`define CHK(got, want) \
    begin tests_run++; if ((got) !== (want)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, got, want); end end
module testbench;
    import encoder_readout_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic load_shift_select, shift_clock, serial_out, light_error_flag, irq;
    logic serial_in = 1'b0, direction_invert = 1'b0, gray_correction_enable = 1'b0;
    logic sine_digital = 1'b0, cosine_digital = 1'b0, light_low = 1'b0;
    logic [TRACK_W-1:0] track_bits = '0;
    logic [INTERP_W-1:0] interp_bits = '0;
    logic sine_digital_test_out, cosine_digital_test_out;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, d;
    logic [STRB_W-1:0] wstrb = '0;
    logic [1:0] bresp, rresp, r;
    logic [15:0] e;
    int err_total = 0;
    int tests_run = 0;
    int lens[$] = '{16, 12, 13, 14, 15, 16};

    // 20 MHz system clock
    always #25 clk = ~clk;

    encoder_serial_position_readout dut (.clk(clk), .rstn(rstn), .load_shift_select(load_shift_select),
        .shift_clock(shift_clock), .serial_in(serial_in), .direction_invert(direction_invert),
        .gray_correction_enable(gray_correction_enable), .sine_digital(sine_digital),
        .cosine_digital(cosine_digital), .track_bits(track_bits), .interp_bits(interp_bits),
        .light_low(light_low), .serial_out(serial_out), .light_error_flag(light_error_flag),
        .sine_digital_test_out(sine_digital_test_out), .cosine_digital_test_out(cosine_digital_test_out),
        .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    shift_controller_model ctl (.load_shift_select(load_shift_select), .shift_clock(shift_clock),
        .serial_out(serial_out));

    // Reference word: top bit direction-adjusted, lowest track bit corrected
    function automatic logic [15:0] exp_word(input logic inv, input logic cor);
        return {track_bits[10] ^ inv, track_bits[9:1], cor ? cosine_digital : track_bits[0],
            sine_digital, interp_bits};
    endfunction : exp_word

    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle

    // Write: AW and W offered together, each dropped when taken
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v, output logic [1:0] rs);
        int n;
        bit ad;
        bit wd;
        @(posedge clk);
        n = 0;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd) && n < 100)
        begin
            @(posedge clk);
            n++;
            if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
            if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
        end
        do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 200);
        rs = bresp;
        bready <= 1'b0;
        if (n >= 200) begin err_total++; close_out(); end
    endtask : axi_wr

    // Read: hold AR until taken, hold rready until rvalid
    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v, output logic [1:0] rs);
        int n;
        @(posedge clk);
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 200);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 200) begin err_total++; close_out(); end
    endtask : axi_rd

    task automatic rand_pins();
        track_bits <= 11'($urandom());
        interp_bits <= 4'($urandom());
        sine_digital <= 1'($urandom());
        cosine_digital <= 1'($urandom());
        serial_in <= 1'($urandom());
    endtask : rand_pins

    // Hang guard
    initial
    begin
        #3000000;
        err_total++;
        close_out();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        void'($urandom(57));
        axi_rd(OFS_STATUS, d, r);
        `CHK(d, 32'h0)
        axi_rd(OFS_MASK, d, r);
        `CHK(d, 32'h0)
        axi_rd(OFS_CTRL, d, r);
        `CHK(d, 32'h0)
        axi_rd(8'h20, d, r);
        `CHK({r, d}, {RESP_SLVERR, 32'h0})
        axi_wr(8'h20, 32'hffffffff, r);
        `CHK(r, RESP_SLVERR)
        // Load mode shows the top bit, inverted on request
        for (int k = 0; k < 4; k++)
        begin
            rand_pins();
            direction_invert <= k[0];
            settle(8);
            `CHK(serial_out, track_bits[10] ^ direction_invert)
        end
        axi_wr(OFS_CTRL, 32'h7, r);
        settle(6);
        `CHK(serial_out, ~track_bits[10])
        axi_rd(OFS_POSITION, d, r);
        `CHK(d[15:0], exp_word(1'b1, 1'b1))
        axi_wr(OFS_CTRL, 32'h0, r);
        // Frames of 12 to 16 bits; pins scrambled mid-shift must not leak in
        foreach (lens[k])
        begin
            rand_pins();
            gray_correction_enable <= k[0];
            direction_invert <= k[1];
            axi_wr(OFS_STATUS, 32'h7, r);
            settle(8);
            e = exp_word(direction_invert, gray_correction_enable);
            fork
                ctl.read_frame(lens[k]);
                begin settle(30); track_bits <= ~track_bits; interp_bits <= ~interp_bits; end
            join
            `CHK(ctl.word_got, e >> (16 - lens[k]))
            axi_rd(OFS_LINK, d, r);
            `CHK(d[6:2], 5'(lens[k]))
            axi_rd(OFS_STATUS, d, r);
            `CHK(d[2:0], (lens[k] == 16) ? 3'h6 : 3'h2)
            axi_rd(OFS_POSITION, d, r);
            `CHK(d[15:0], e)
            ctl.park();
        end
        // Light error, sticky status, mask and clear
        axi_wr(OFS_STATUS, 32'h7, r);
        axi_wr(OFS_MASK, 32'h1, r);
        light_low <= 1'b1;
        settle(8);
        `CHK({light_error_flag, irq}, 2'b11)
        axi_wr(OFS_MASK, 32'h0, r);
        settle(2);
        `CHK(irq, 1'b0)
        axi_wr(OFS_MASK, 32'h1, r);
        axi_wr(OFS_STATUS, 32'h1, r);
        settle(2);
        `CHK(irq, 1'b0)
        light_low <= 1'b0;
        settle(8);
        `CHK(light_error_flag, 1'b0)
        // Test outputs follow the digitized channels
        for (int k = 0; k < 4; k++)
        begin
            sine_digital <= k[0];
            cosine_digital <= k[1];
            settle(6);
            `CHK({sine_digital_test_out, cosine_digital_test_out}, {k[0], k[1]})
        end
        close_out();
    end
endmodule : testbench
